/* test/handler_model.sv */
// Component handler model that bins parts on the end-of-test strobe
`timescale 1ns/100ps
`default_nettype none
module handler_model (
  // Clock and tester lines
  input wire logic sys_clk,
  input wire logic [3:0] handler_lines,
  // Category caught at the last strobe
  output logic [2:0] bin
);
  logic last;
  // Sample on the strobe rise, while the skew still gives setup margin
  always @(posedge sys_clk) begin
    last <= handler_lines[3];
    if (handler_lines[3] && !last) bin <= handler_lines[2:0];
  end
endmodule
`default_nettype wire

/* test/handler_output_autoclear_props.sv */
// Checker of handler line timing and settings
`timescale 1ns/100ps
`default_nettype none
module autoclear_props (
  // Clock, reset and requests
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic auto_clear_enable_wr,
  input wire logic auto_clear_enable_in,
  input wire logic clear_now_request,
  input wire logic pattern_valid,
  input wire logic [3:0] output_level,
  input wire logic [2:0] pattern_category,
  // Readback and lines
  input wire logic auto_clear_enable,
  input wire logic end_of_test_strobe,
  input wire logic busy,
  input wire logic [25:0] auto_clear_delay,
  input wire logic [25:0] auto_clear_delay_min,
  input wire logic [25:0] auto_clear_delay_max,
  input wire logic [25:0] auto_clear_delay_default,
  input wire logic [3:0] handler_lines
);
  logic [31:0] hi;
  logic [25:0] dl;
  // Strobe width count and the delay latched with each pattern
  always @(posedge sys_clk) begin
    hi <= end_of_test_strobe ? hi + 32'h1 : 32'h0;
    if (pattern_valid) dl <= auto_clear_delay;
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  clear_restore_a: assert property (clear_now_request |=> handler_lines == $past(output_level))
    else $error("clear request did not restore level");
  enable_store_a: assert property (auto_clear_enable_wr |=> auto_clear_enable == $past(auto_clear_enable_in))
    else $error("enable readback wrong");
  reset_value_a: assert property ($rose(nrst) |-> auto_clear_enable && auto_clear_delay == 26'h64 && !busy)
    else $error("reset values wrong");
  delay_limits_a: assert property (auto_clear_delay_max == 26'h3938700 && auto_clear_delay_min == 26'h0
    && auto_clear_delay_default == 26'h64) else $error("delay limits wrong");
  pattern_show_a: assert property (pattern_valid && !clear_now_request |=> busy
    && handler_lines == {$past(output_level[3]), $past(pattern_category)}) else $error("pattern not shown");
  lead_skew_a: assert property ($rose(end_of_test_strobe) |-> $past(pattern_valid, 201))
    else $error("strobe lead wrong");
  strobe_width_a: assert property ($fell(end_of_test_strobe) && !$past(clear_now_request)
    && !$past(pattern_valid) |-> hi == dl * 20) else $error("strobe width wrong");
  trail_clear_a: assert property ($fell(end_of_test_strobe) && !$past(clear_now_request)
    && !$past(pattern_valid) |-> ##200 handler_lines == output_level) else $error("trail clear wrong");
  cover property ($rose(end_of_test_strobe));
  cover property (clear_now_request && end_of_test_strobe);
  cover property (pattern_valid && busy);
endmodule
bind handler_output_autoclear autoclear_props i_autoclear_props (.sys_clk, .nrst, .auto_clear_enable_wr,
  .auto_clear_enable_in, .clear_now_request, .pattern_valid, .output_level, .pattern_category, .auto_clear_enable,
  .end_of_test_strobe, .busy, .auto_clear_delay, .auto_clear_delay_min, .auto_clear_delay_max,
  .auto_clear_delay_default, .handler_lines);
`default_nettype wire

/* test/handler_output_autoclear_test.sv */
// Self-checking bench for the handler output block
`timescale 1ns/100ps
`default_nettype none
module handler_output_autoclear_test;
  logic sys_clk, nrst, en_in, en, rej, stb, busy;
  logic [3:0] req, lvl, lines;
  logic [25:0] dl_in, dmin, dmax, ddef, dly;
  logic [2:0] cat, bin;
  int error_cnt = 0;
  int checks = 0;
  handler_output_autoclear i_handler_output_autoclear (.sys_clk(sys_clk), .nrst(nrst), .output_level(lvl),
    .auto_clear_enable_wr(req[0]), .auto_clear_enable_in(en_in), .auto_clear_delay_wr(req[1]),
    .auto_clear_delay_in(dl_in), .clear_now_request(req[3]), .pattern_valid(req[2]), .pattern_category(cat),
    .auto_clear_enable(en), .auto_clear_delay(dly), .auto_clear_delay_min(dmin), .auto_clear_delay_max(dmax),
    .auto_clear_delay_default(ddef), .delay_rejected(rej), .handler_lines(lines), .end_of_test_strobe(stb),
    .busy(busy));
  handler_model i_handler_model (.sys_clk(sys_clk), .handler_lines(lines), .bin(bin));
  task cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  // One-cycle request k: 0 enable, 1 delay, 2 pattern, 3 clear
  task req_pulse(input int k, input logic [25:0] v);
    @(negedge sys_clk);
    en_in = v[0];
    dl_in = v;
    cat = v[2:0];
    req[k] = 1'b1;
    @(negedge sys_clk);
    req[k] = 1'b0;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task finish_test;
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  // Whole run is near 2450 cycles; allow well over that
  initial begin
    #500000;
    error_cnt++;
    finish_test;
  end
  initial begin
    {req, en_in, dl_in, cat} = 0;
    lvl = 4'h2;
    nrst = 1'b0;
    cyc(2);
    nrst = 1'b1;
    chk(en, 1);
    chk(ddef, 26'h64);
    chk(dly, 26'h64);
    chk(dmin, 26'h0);
    chk(dmax, 26'h3938700);
    req_pulse(0, 0);
    chk(en, 0);
    req_pulse(0, 1);
    chk(en, 1);
    req_pulse(1, 26'h3938701);
    chk({rej, dly}, {1'b1, 26'h64});
    req_pulse(1, 26'h3938700);
    chk({rej, dly}, {1'b0, 26'h3938700});
    req_pulse(1, 2);
    // Short 2 us strobe keeps the run brief
    req_pulse(2, 5);
    chk(lines, 4'h5);
    cyc(300);
    chk({bin, stb, lines}, {3'h5, 1'b0, 4'h5});
    cyc(150);
    chk({busy, lines}, {1'b0, 4'h2});
    // Second pattern mid-lead restarts the sequence
    req_pulse(2, 3);
    cyc(100);
    req_pulse(2, 6);
    cyc(100);
    chk(stb, 0);
    cyc(200);
    chk(bin, 6);
    cyc(150);
    chk(lines, 4'h2);
    req_pulse(0, 0);
    req_pulse(2, 1);
    cyc(1000);
    chk({stb, lines}, {1'b1, 4'h9});
    req_pulse(3, 0);
    chk({stb, lines}, {1'b0, 4'h2});
    req_pulse(0, 1);
    req_pulse(1, 0);
    req_pulse(2, 7);
    cyc(300);
    chk({stb, lines}, {1'b0, 4'h7});
    cyc(120);
    chk(lines, 4'h2);
    finish_test;
  end
endmodule
`default_nettype wire

/* verilog/handler_out_defs.vh */
// Constants for the handler output auto-clear block
`ifndef HANDLER_OUT_DEFS_VH
`define HANDLER_OUT_DEFS_VH
// Clock rate in Hz (50 ns period)
`define CLK_HZ 20000000
// Delay units: the delay port counts microseconds
`define DELAY_W 26
// Maximum delay 60 s, in microseconds
`define DELAY_MAX_US 26'h3938700
// Minimum delay 0 s
`define DELAY_MIN_US 26'h0000000
// Default delay 100 us
`define DELAY_DEF_US 26'h0000064
// Skew of category lines around the strobe, in microseconds
`define SKEW_US 10
// Cycles per microsecond (rate / 1e6)
`define CYC_PER_US (`CLK_HZ / 1000000)
// Skew in cycles: 10 us at 20 MHz, sized to the skew counter
`define SKEW_CYC 9'h0c8
// Last count of the microsecond divider: 20 cycles, counted 0 to 19
`define TICK_LAST 5'h13
// Auto-clear enabled after reset
`define AUTO_CLEAR_RST 1'b1
// Default output level after reset
`define LEVEL_RST 4'h0
`endif

/* verilog/handler_output_autoclear.v */
// Four-line handler output with pass/fail pattern, strobe timing and auto-clear
`timescale 1ns/100ps
`default_nettype none
`include "handler_out_defs.vh"
module handler_output_autoclear (
  // Clock and reset
  input wire sys_clk,
  input wire nrst,
  // Configuration
  input wire [3:0] output_level,
  input wire auto_clear_enable_wr,
  input wire auto_clear_enable_in,
  input wire auto_clear_delay_wr,
  input wire [25:0] auto_clear_delay_in,
  // Requests
  input wire clear_now_request,
  input wire pattern_valid,
  input wire [2:0] pattern_category,
  // Readback
  output reg auto_clear_enable,
  output reg [25:0] auto_clear_delay,
  output wire [25:0] auto_clear_delay_min,
  output wire [25:0] auto_clear_delay_max,
  output wire [25:0] auto_clear_delay_default,
  output reg delay_rejected,
  // Handler lines; bit 3 is the end-of-test strobe
  output reg [3:0] handler_lines,
  output reg end_of_test_strobe,
  output wire busy
);
  // Timing of one result, in edges after the take edge T, for a delay of D us:
  // T takes the pattern and shows it on lines 0-2 with line 4 at bit 3 of output_level;
  // T+200 raises line 4 and the strobe after the 10 us lead skew;
  // T+200+20D drops the strobe and sets line 4 to bit 3 of output_level after D whole microseconds;
  // T+400+20D returns every line to the programmed level.
  // A zero delay skips the strobe, so the lines return at T+400.
  // Skews count cycles, the strobe counts microsecond ticks, which keeps
  // a 60 s delay within a 26-bit counter instead of a 31-bit one.
  // Limitations to keep in mind:
  // the enable is looked at only as the lead skew ends, so a write during
  // the lead decides whether this result is held or auto-cleared;
  // a held pattern keeps line 4 high until a clear request or a new take arrives;
  // output_level is read at the strobe and trail ends, not latched with the take;
  // a new take during the trail skew cuts the trail short.

  // Sequencer states
  localparam [1:0] ST_IDLE = 2'b00;
  localparam [1:0] ST_LEAD = 2'b01;
  localparam [1:0] ST_STROBE = 2'b10;
  localparam [1:0] ST_TRAIL = 2'b11;
  localparam [8:0] SKEW = `SKEW_CYC;

  // Sequencer state and counters
  reg [1:0] state;
  reg [8:0] skew_count;
  reg [25:0] us_count;
  reg [25:0] active_delay;
  reg [2:0] held_pattern;
  reg held;
  // Phase decisions
  wire tick;
  wire restart;
  wire lead_done;
  wire strobe_done;
  wire trail_done;
  wire skew_phase;

  // Query answers are constants
  assign auto_clear_delay_min = `DELAY_MIN_US;
  assign auto_clear_delay_max = `DELAY_MAX_US;
  assign auto_clear_delay_default = `DELAY_DEF_US;
  assign busy = (state != ST_IDLE) || held;

  // Phase ends; the strobe ends on the tick that completes the last microsecond
  // Both skews share one counter since they never overlap
  assign skew_phase = (state == ST_LEAD) || (state == ST_TRAIL);
  assign lead_done = (state == ST_LEAD) && (skew_count == SKEW - 9'h001);
  assign trail_done = (state == ST_TRAIL) && (skew_count == SKEW - 9'h001);
  assign strobe_done = (state == ST_STROBE) && tick && (us_count == active_delay - 26'h0000001);

  // Tick phase is realigned as the strobe rises, so its width is exact
  assign restart = pattern_valid || lead_done;

  // Microsecond time base for the strobe width
  us_tick u_tick (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .restart(restart),
    .tick(tick)
  );

  // Auto-clear enable; the sequencer samples it only at the end of the lead skew
  always @(posedge sys_clk) begin
    if (!nrst) begin
      auto_clear_enable <= `AUTO_CLEAR_RST;
    end else if (auto_clear_enable_wr) begin
      auto_clear_enable <= auto_clear_enable_in;
    end
  end

  // Delay setting; an out-of-range write is refused and flagged, old value kept
  always @(posedge sys_clk) begin
    if (!nrst) begin
      auto_clear_delay <= `DELAY_DEF_US;
      delay_rejected <= 1'b0;
    end else if (auto_clear_delay_wr) begin
      if (auto_clear_delay_in > `DELAY_MAX_US) begin
        delay_rejected <= 1'b1;
      end else begin
        auto_clear_delay <= auto_clear_delay_in;
        delay_rejected <= 1'b0;
      end
    end
  end

  // Skew counter for lead and trail; a take or a clear starts it from zero
  always @(posedge sys_clk) begin
    if (!nrst || clear_now_request || pattern_valid) begin
      skew_count <= 9'h000;
    end else if (lead_done || trail_done) begin
      skew_count <= 9'h000;
    end else if (skew_phase) begin
      skew_count <= skew_count + 9'h001;
    end
  end

  // Whole microseconds of strobe shown so far
  always @(posedge sys_clk) begin
    if (!nrst || clear_now_request || pattern_valid) begin
      us_count <= 26'h0000000;
    end else if (state == ST_STROBE && tick && !strobe_done) begin
      us_count <= us_count + 26'h0000001;
    end
  end

  // Sequencer: lead skew, strobe for the delay, trail skew, then clear
  always @(posedge sys_clk) begin
    if (!nrst) begin
      // Lines start at the reset level, strobe low
      state <= ST_IDLE;
      active_delay <= 26'h0000000;
      held_pattern <= 3'h0;
      held <= 1'b0;
      handler_lines <= `LEVEL_RST;
      end_of_test_strobe <= 1'b0;
    end else if (clear_now_request) begin
      // Clear wins over everything except reset, including a new pattern
      state <= ST_IDLE;
      held <= 1'b0;
      end_of_test_strobe <= 1'b0;
      handler_lines <= output_level;
    end else if (pattern_valid) begin
      // New pattern drops any pending one and restarts timing
      state <= ST_LEAD;
      active_delay <= auto_clear_delay;
      held_pattern <= pattern_category;
      held <= 1'b0;
      end_of_test_strobe <= 1'b0;
      handler_lines <= {output_level[3], pattern_category};
    end else begin
      case (state)

        // Lead: category lines settle before the strobe
        ST_LEAD: begin
          if (lead_done) begin
            if (!auto_clear_enable) begin
              // Disabled: raise strobe and hold indefinitely
              state <= ST_IDLE;
              held <= 1'b1;
              end_of_test_strobe <= 1'b1;
              handler_lines <= {1'b1, held_pattern};
            end else if (active_delay == 26'h0000000) begin
              // Zero delay: no strobe pulse, only the skews
              state <= ST_TRAIL;
            end else begin
              state <= ST_STROBE;
              end_of_test_strobe <= 1'b1;
              handler_lines <= {1'b1, held_pattern};
            end
          end
        end

        // Strobe: line 4 high for the latched delay
        ST_STROBE: begin
          if (strobe_done) begin
            // Strobe width equals programmed delay
            state <= ST_TRAIL;
            end_of_test_strobe <= 1'b0;
            handler_lines <= {output_level[3], held_pattern};
          end
        end

        // Trail: category lines held as hold margin after the strobe
        ST_TRAIL: begin
          if (trail_done) begin
            // Expiry returns the programmed level
            state <= ST_IDLE;
            handler_lines <= output_level;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

/* verilog/us_tick.v */
// Microsecond tick generator from the system clock
`timescale 1ns/100ps
`default_nettype none
`include "handler_out_defs.vh"
module us_tick (
  // Clock and reset
  input wire sys_clk,
  input wire nrst,
  // Restart the count
  input wire restart,
  // One-cycle pulse every microsecond
  output reg tick
);
  localparam [4:0] LAST = `TICK_LAST;
  reg [4:0] count;

  // Restart loads one so the first tick is seen exactly 20 edges after the restart edge
  always @(posedge sys_clk) begin
    if (!nrst) begin
      count <= 5'h00;
      tick <= 1'b0;
    end else if (restart) begin
      count <= 5'h01;
      tick <= 1'b0;
    end else if (count == LAST) begin
      count <= 5'h00;
      tick <= 1'b1;
    end else begin
      count <= count + 5'h01;
      tick <= 1'b0;
    end
  end
endmodule
`default_nettype wire
